// *** common/spc_pkg.sv ***
// Behaviour
// [RULE1] the flash error flag is set when a flash error shows after power-up and before any play.
// [RULE2] with the flash error flag set before playback the host resets the chip or powers it down.
// [RULE3] a stopped resonator clock is detected and operation goes on from the RC oscillator.
// [RULE4] a read-error command taken during the switchover keeps busy low until it completes.
// [RULE5] the host waits for busy to return high before reading the read-error answer.
// [RULE6] after seeing the oscillator failure flag the host stops playback.
// [RULE7] read data is refreshed only by the read-status, read-error and read-version commands.
// [RULE8] the host pulses reset low once after power-on before its first command.
// [RULE9] the host issues power-down before switching any supply off.
// [RULE10] the analog volume setting reaches the speaker gain only with the Class AB amplifier.
// [RULE11] with the Class D amplifier the gain is fixed at +0.0dB whatever the volume setting.
// [RULE12] for gapless playback the host sends the next play within the limit after ready rises.
// [RULE13] that limit time is 10 ms.
// [RULE14] for non-gapless playback the host confirms the phrase ended before the next play.
// [RULE15] each channel has a next-phrase-ready signal, high when it can take its next phrase; the code keeps it low while the channel is idle.
package spc_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_OFFSET       = 8'h00;
	localparam logic [7:0] READ_DATA_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_OFFSET    = 8'h08;
	localparam logic [7:0] IRQ_STAT_OFFSET  = 8'h0c;
	localparam logic [7:0] IRQ_MASK_OFFSET  = 8'h10;
	localparam logic [7:0] GAIN_OFFSET      = 8'h14;

	// ------------------------------------------------------------
	// commands: opcode in bits 7:0, argument in bits 11:8
	// ------------------------------------------------------------
	localparam logic [7:0] OP_POWER_UP     = 8'h01;
	localparam logic [7:0] OP_POWER_DOWN   = 8'h02;
	localparam logic [7:0] OP_READ_STATUS  = 8'h03;
	localparam logic [7:0] OP_READ_ERROR   = 8'h04;
	localparam logic [7:0] OP_READ_VERSION = 8'h05;
	localparam logic [7:0] OP_ANALOG_VOL   = 8'h06;
	localparam logic [7:0] OP_PLAY         = 8'h07;
	localparam logic [7:0] OP_STOP         = 8'h08;
	localparam logic [7:0] OP_AMP_SELECT   = 8'h09;
	localparam int         ARG_LSB         = 8;

	localparam int         CHANNELS        = 4;
	localparam logic [3:0] GAIN_0DB        = 4'hc;
	localparam logic [3:0] VOL_RESET       = 4'h0;

	// irq bits
	localparam int IRQ_FLASH = 0;
	localparam int IRQ_OSC   = 1;
	localparam int IRQ_READY = 2;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ        = 100;
	localparam int SWITCH_TIME_US = 500;
	localparam int SWITCH_CYC     = SWITCH_TIME_US * CLK_MHZ;
	localparam int STOP_TIME_NS   = 1000;
	localparam int STOP_CYC       = (STOP_TIME_NS * CLK_MHZ + 999) / 1000;

	typedef enum logic [1:0] {
		OSC_XTAL   = 2'b00,
		OSC_SWITCH = 2'b01,
		OSC_RC     = 2'b11
	} spc_osc_type;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} spc_apb_req_type;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} spc_apb_rsp_type;
endpackage : spc_pkg

// *** design/spc_sequencer.sv ***
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module spc_sequencer #(
	parameter int         SWITCH_CYCLES = spc_pkg::SWITCH_CYC,
	parameter logic [7:0] VERSION_CODE  = 8'h5a // arbitrary
) (
	input  wire logic                              clk_in,
	input  wire logic                              reset_in,
	input  wire spc_pkg::spc_apb_req_type          apb_in,
	output spc_pkg::spc_apb_rsp_type               apb_out,
	input  wire logic                              xtal_clk_in,
	input  wire logic                              flash_err_in,
	input  wire logic [spc_pkg::CHANNELS-1:0]      chan_done_in,
	output logic [spc_pkg::CHANNELS-1:0]           next_phrase_ready_out,
	output logic [spc_pkg::CHANNELS-1:0]           play_start_out,
	output logic                                   cmd_busy_n_out,
	output logic                                   rc_mode_out,
	output logic [3:0]                             gain_out,
	output logic                                   irq_out
);
	import spc_pkg::*;

	// the switchover counter is only 24 bits wide
	if (SWITCH_CYCLES < 1 || SWITCH_CYCLES > 32'h00ffffff) begin : g_bad_switch
		$error("switch cycles out of range");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [2:0]          xtal_sync, next_xtal_sync;
	logic [7:0]          stop_count, next_stop_count;
	logic [23:0]         switch_count, next_switch_count;
	spc_osc_type         osc_state, next_osc_state;
	logic                osc_fail_flag, next_osc_fail_flag;
	logic                flash_error_flag, next_flash_error_flag;
	logic                powered, next_powered;
	logic                played, next_played;
	logic                err_read_wait, next_err_read_wait;
	logic [31:0]         read_data, next_read_data;
	logic                amp_class_d, next_amp_class_d;
	logic [3:0]          volume, next_volume;
	logic [CHANNELS-1:0] active, next_active;
	logic [CHANNELS-1:0] pending, next_pending;
	logic [2:0]          irq_stat, next_irq_stat;
	logic [2:0]          irq_mask, next_irq_mask;
	spc_apb_rsp_type     next_apb;
	logic [CHANNELS-1:0] next_ready, next_start;
	logic                next_busy_n, next_irq;
	logic [3:0]          next_gain;

	logic                wr, cmd_wr, refresh;
	logic [7:0]          opcode;
	logic [3:0]          arg;
	logic [2:0]          events;

	function automatic logic [31:0] error_word(input logic osc, input logic flash);
		error_word = {30'h0, osc, flash};
	endfunction : error_word

	assign wr     = apb_in.psel && apb_in.penable && apb_out.pready && apb_in.pwrite;
	assign cmd_wr = wr && apb_in.paddr == CMD_OFFSET;
	assign opcode = apb_in.pwdata[7:0];
	assign arg    = apb_in.pwdata[ARG_LSB+3:ARG_LSB];

	// ------------------------------------------------------------
	// resonator watch and RC switchover
	// ------------------------------------------------------------
	always_comb begin
		next_xtal_sync    = {xtal_sync[1:0], xtal_clk_in};
		next_stop_count   = stop_count;
		next_switch_count = switch_count;
		next_osc_state    = osc_state;
		case (osc_state)
			OSC_XTAL: begin
				// any edge of the synchronised clock restarts the watch
				if (xtal_sync[2] != xtal_sync[1])
					next_stop_count = 8'h00;
				else if (stop_count >= 8'(STOP_CYC - 1)) begin
					next_osc_state    = OSC_SWITCH; // RULE3
					next_switch_count = 24'h000000;
				end else
					next_stop_count = stop_count + 8'h01;
			end
			OSC_SWITCH: begin
				if (switch_count >= 24'(SWITCH_CYCLES - 1))
					next_osc_state = OSC_RC; // RULE3
				else
					next_switch_count = switch_count + 24'h000001;
			end
			default: next_osc_state = OSC_RC; // no way back short of reset
		endcase
	end

	// ------------------------------------------------------------
	// command interpreter
	// ------------------------------------------------------------
	always_comb begin
		next_flash_error_flag = flash_error_flag;
		next_osc_fail_flag    = osc_fail_flag || next_osc_state == OSC_SWITCH;
		next_powered          = powered;
		next_played           = played;
		next_err_read_wait    = err_read_wait;
		next_read_data        = read_data;
		next_amp_class_d      = amp_class_d;
		next_volume           = volume;
		next_active           = active;
		next_pending          = pending;
		next_start            = '0;
		refresh               = 1'b0;
		// a phrase ending either chains the pending one or idles the channel
		for (int c = 0; c < CHANNELS; c++) begin
			if (chan_done_in[c] && active[c]) begin
				next_active[c]  = pending[c];
				next_pending[c] = 1'b0;
				next_start[c]   = pending[c];
			end
		end
		if (powered && !played && flash_err_in)
			next_flash_error_flag = 1'b1; // RULE1
		if (cmd_wr) begin
			case (opcode)
				OP_POWER_UP: begin
					next_powered = 1'b1;
					next_played  = 1'b0;
				end
				OP_POWER_DOWN: begin
					next_powered          = 1'b0;
					next_played           = 1'b0;
					next_flash_error_flag = 1'b0;
					next_active           = '0;
					next_pending          = '0;
				end
				OP_READ_STATUS: begin
					next_read_data = {24'h0, pending, active};
					refresh        = 1'b1; // RULE7
				end
				OP_READ_ERROR: begin
					// the answer waits for the clock source to settle
					if (osc_state == OSC_SWITCH)
						next_err_read_wait = 1'b1; // RULE4
					else begin
						next_read_data = error_word(next_osc_fail_flag, next_flash_error_flag);
						refresh        = 1'b1; // RULE7
					end
				end
				OP_READ_VERSION: begin
					next_read_data = {24'h0, VERSION_CODE};
					refresh        = 1'b1; // RULE7
				end
				OP_ANALOG_VOL: next_volume = arg;
				OP_AMP_SELECT: next_amp_class_d = arg[0];
				OP_PLAY: begin
					if (powered) begin
						next_played = 1'b1;
						// a phrase chained in this cycle still queues the new one
						if (next_active[arg[1:0]])
							next_pending[arg[1:0]] = 1'b1;
						else begin
							next_active[arg[1:0]] = 1'b1;
							next_start[arg[1:0]]  = 1'b1;
						end
					end
				end
				OP_STOP: begin
					next_active[arg[1:0]]  = 1'b0;
					next_pending[arg[1:0]] = 1'b0;
					next_start[arg[1:0]]   = 1'b0;
				end
				default: ;
			endcase
		end
		if (err_read_wait && osc_state == OSC_RC) begin
			next_err_read_wait = 1'b0;
			next_read_data     = error_word(osc_fail_flag, flash_error_flag);
			refresh            = 1'b1; // RULE7
		end
		next_busy_n = !next_err_read_wait; // RULE4
		next_ready  = next_active & ~next_pending; // RULE15
		// class D runs at fixed unity gain
		next_gain   = next_amp_class_d ? GAIN_0DB : next_volume; // RULE10 RULE11
	end

	// ------------------------------------------------------------
	// apb slave and interrupts
	// ------------------------------------------------------------
	always_comb begin
		events        = {|(next_ready & ~next_phrase_ready_out),
			next_osc_fail_flag && !osc_fail_flag,
			next_flash_error_flag && !flash_error_flag};
		next_irq_stat = irq_stat;
		next_irq_mask = irq_mask;
		next_apb      = '0;
		if (wr && apb_in.paddr == IRQ_STAT_OFFSET)
			next_irq_stat = irq_stat & ~apb_in.pwdata[2:0];
		if (wr && apb_in.paddr == IRQ_MASK_OFFSET)
			next_irq_mask = apb_in.pwdata[2:0];
		// set wins over a clear in the same cycle
		next_irq_stat = next_irq_stat | events;
		next_irq      = |(next_irq_stat & next_irq_mask);
		// answer lands in the first cycle of the access phase
		if (apb_in.psel && !apb_in.penable) begin
			next_apb.pready = 1'b1;
			if (apb_in.paddr == CMD_OFFSET)
				next_apb.prdata = 32'h0;
			else if (apb_in.paddr == READ_DATA_OFFSET)
				next_apb.prdata = read_data;
			else if (apb_in.paddr == STATUS_OFFSET)
				next_apb.prdata = {25'h0, amp_class_d, powered, osc_state == OSC_RC,
					!err_read_wait, osc_fail_flag, flash_error_flag, played};
			else if (apb_in.paddr == IRQ_STAT_OFFSET)
				next_apb.prdata = {29'h0, irq_stat};
			else if (apb_in.paddr == IRQ_MASK_OFFSET)
				next_apb.prdata = {29'h0, irq_mask};
			else if (apb_in.paddr == GAIN_OFFSET)
				next_apb.prdata = {24'h0, volume, gain_out};
			else
				next_apb.pslverr = 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			xtal_sync             <= 3'h0;
			stop_count            <= 8'h00;
			switch_count          <= 24'h000000;
			osc_state             <= OSC_XTAL;
			osc_fail_flag         <= 1'b0;
			flash_error_flag      <= 1'b0;
			powered               <= 1'b0;
			played                <= 1'b0;
			err_read_wait         <= 1'b0;
			read_data             <= 32'h0;
			amp_class_d           <= 1'b0;
			volume                <= VOL_RESET;
			active                <= '0;
			pending               <= '0;
			irq_stat              <= 3'h0;
			irq_mask              <= 3'h0;
			apb_out               <= '0;
			next_phrase_ready_out <= '0;
			play_start_out        <= '0;
			cmd_busy_n_out        <= 1'b1;
			rc_mode_out           <= 1'b0;
			gain_out              <= VOL_RESET;
			irq_out               <= 1'b0;
		end else begin
			xtal_sync             <= next_xtal_sync;
			stop_count            <= next_stop_count;
			switch_count          <= next_switch_count;
			osc_state             <= next_osc_state;
			osc_fail_flag         <= next_osc_fail_flag;
			flash_error_flag      <= next_flash_error_flag;
			powered               <= next_powered;
			played                <= next_played;
			err_read_wait         <= next_err_read_wait;
			read_data             <= next_read_data;
			amp_class_d           <= next_amp_class_d;
			volume                <= next_volume;
			active                <= next_active;
			pending               <= next_pending;
			irq_stat              <= next_irq_stat;
			irq_mask              <= next_irq_mask;
			apb_out               <= next_apb;
			next_phrase_ready_out <= next_ready;
			play_start_out        <= next_start;
			cmd_busy_n_out        <= next_busy_n;
			rc_mode_out           <= next_osc_state == OSC_RC;
			gain_out              <= next_gain;
			irq_out               <= next_irq;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	sequence err_read_in_switch;
		cmd_wr && opcode == OP_READ_ERROR && osc_state == OSC_SWITCH;
	endsequence
	sequence busy_held_low;
		!cmd_busy_n_out [*2];
	endsequence

	flash_set_a: assert property ( // RULE1
		powered && !played && flash_err_in && !cmd_wr |=> flash_error_flag)
		else $error("flash error not flagged");
	osc_detect_a: assert property ( // RULE3
		$rose(osc_fail_flag) |-> osc_state == OSC_SWITCH && !rc_mode_out)
		else $error("osc fail without switchover");
	switch_bound_a: assert property ( // RULE3
		osc_state == OSC_SWITCH |-> switch_count < 24'(SWITCH_CYCLES))
		else $error("switchover overran");
	busy_low_a: assert property ( // RULE4
		err_read_in_switch ##1 (osc_state == OSC_SWITCH) |-> busy_held_low)
		else $error("busy not held during switchover");
	busy_release_a: assert property ( // RULE4
		$rose(cmd_busy_n_out) |-> rc_mode_out && read_data[1])
		else $error("busy released before rc");
	read_refresh_a: assert property ( // RULE7
		$changed(read_data) |-> $past(refresh))
		else $error("read data changed without read command");
	gain_ab_a: assert property ( // RULE10
		!amp_class_d |-> gain_out == volume)
		else $error("class ab gain not volume");
	gain_d_a: assert property ( // RULE11
		amp_class_d |-> gain_out == GAIN_0DB)
		else $error("class d gain not 0dB");
	ready_map_a: assert property ( // RULE15
		next_phrase_ready_out == (active & ~pending))
		else $error("next phrase ready mismatch");
endmodule : spc_sequencer

// *** test/spc_engine_model.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// resonator and playback engine stand-in
// ------------------------------------------------------------
module spc_engine_model (
	input  wire logic       clk_in,
	input  wire logic       xtal_run_in,
	input  wire logic [3:0] done_req_in,
	output logic            xtal_clk_out,
	output logic [3:0]      chan_done_out
);
	logic [3:0] req_q;

	initial begin
		xtal_clk_out = 1'b0;
		req_q = 4'h0;
		chan_done_out = 4'h0;
	end

	// a dead resonator freezes where it stopped, it does not float
	always #40 if (xtal_run_in) xtal_clk_out = ~xtal_clk_out;

	// one-cycle phrase end per request edge
	always @(posedge clk_in) begin
		req_q <= done_req_in;
		chan_done_out <= done_req_in & ~req_q;
	end
endmodule : spc_engine_model

// *** test/speech_playback_command_sequencing_test.sv ***
`timescale 1ns/1ns
module speech_playback_command_sequencing_test;
	import spc_pkg::*;
	logic            clk_in = 1'b0;
	logic            reset_in = 1'b1;
	spc_apb_req_type req = '0;
	spc_apb_rsp_type rsp;
	logic            xtal_run = 1'b1;
	logic            xtal_clk;
	logic            flash_err = 1'b0;
	logic [3:0]      done_req = 4'h0;
	logic [3:0]      chan_done, ready, starts, gain;
	logic            busy_n, rc_mode, irq, err;
	logic [31:0]     seed = 32'h31b6;
	logic [31:0]     rdata;
	int              fail_count = 0;
	int              cmp_count = 0;
	int              cycles = 0;
	int              start_total = 0;
	int              m_start = 0;
	int              ch, w;

	always #5 clk_in = ~clk_in;

	// short switchover keeps the run brief
	spc_sequencer #(.SWITCH_CYCLES(40), .VERSION_CODE(8'h3c)) dut (.clk_in(clk_in),
		.reset_in(reset_in),
		.apb_in(req), .apb_out(rsp), .xtal_clk_in(xtal_clk), .flash_err_in(flash_err),
		.chan_done_in(chan_done), .next_phrase_ready_out(ready), .play_start_out(starts),
		.cmd_busy_n_out(busy_n), .rc_mode_out(rc_mode), .gain_out(gain), .irq_out(irq));

	spc_engine_model model (.clk_in(clk_in), .xtal_run_in(xtal_run), .done_req_in(done_req),
		.xtal_clk_out(xtal_clk), .chan_done_out(chan_done));

	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		start_total <= start_total + $countones(starts);
		if (cycles == 20000) begin
			fail_count++;
			give_verdict();
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// entered just after a rising edge; the idle edge at the end avoids a
	// double assignment when transfers follow each other
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk_in);
		req.penable <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (rsp.pready !== 1'b1 && n < 16);
		rdata = rsp.prdata;
		err = rsp.pslverr;
		if (n >= 16) fail_count++;
		req <= '0;
		@(posedge clk_in);
	endtask : apb

	task automatic cmd(input logic [7:0] op, input logic [3:0] arg);
		apb(1'b1, CMD_OFFSET, {20'h0, arg, op});
	endtask : cmd

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string name);
		apb(1'b0, a, 32'h0);
		chk(name, e, rdata & m);
	endtask : rd

	task automatic pulse(input int kind);
		if (kind == 0) done_req <= 4'(1 << ch);
		else flash_err <= 1'b1;
		repeat (2) @(posedge clk_in);
		done_req <= 4'h0;
		flash_err <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask : pulse

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		rd(STATUS_OFFSET, 32'h8, 32'h8, "busy idle");
		rd(8'h18, 32'hffffffff, 32'h0, "unmapped data");
		chk("unmapped err", 32'h1, {31'h0, err});
		apb(1'b1, IRQ_MASK_OFFSET, 32'h0);
		cmd(OP_POWER_UP, 4'h0);
		pulse(1);
		rd(STATUS_OFFSET, 32'h2, 32'h2, "flash flag");
		rd(READ_DATA_OFFSET, 32'h3, 32'h0, "stale data");
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, IRQ_MASK_OFFSET, 32'h1);
		chk("irq flash", 32'h1, {31'h0, irq});
		apb(1'b1, IRQ_STAT_OFFSET, 32'h1);
		chk("irq cleared", 32'h0, {31'h0, irq});
		cmd(OP_READ_ERROR, 4'h0);
		rd(READ_DATA_OFFSET, 32'h3, 32'h1, "error data");
		cmd(OP_READ_VERSION, 4'h0);
		rd(READ_DATA_OFFSET, 32'hff, 32'h3c, "version data");
		cmd(OP_POWER_DOWN, 4'h0);
		rd(STATUS_OFFSET, 32'h22, 32'h0, "powered down");
		for (int cd = 0; cd < 2; cd++) begin
			seed = lfsr(seed);
			cmd(OP_AMP_SELECT, {3'h0, cd[0]});
			cmd(OP_ANALOG_VOL, seed[3:0]);
			chk("gain", {28'h0, cd[0] ? GAIN_0DB : seed[3:0]}, {28'h0, gain});
			rd(GAIN_OFFSET, 32'hf0, {24'h0, seed[3:0], 4'h0}, "volume");
		end
		// phrase chaining on one random channel
		cmd(OP_POWER_UP, 4'h0);
		apb(1'b1, IRQ_STAT_OFFSET, 32'h7);
		apb(1'b1, IRQ_MASK_OFFSET, 32'h4);
		seed = lfsr(seed);
		ch = int'(seed[1:0]);
		cmd(OP_PLAY, 4'(ch));
		m_start++;
		chk("ready first", 32'(1 << ch), {28'h0, ready});
		chk("ready irq", 32'h1, {31'h0, irq});
		cmd(OP_PLAY, 4'(ch));
		chk("ready queued", 32'h0, {28'h0, ready});
		cmd(OP_READ_STATUS, 4'h0);
		rd(READ_DATA_OFFSET, 32'hff, 32'(17 << ch), "status data");
		pulse(0);
		m_start++;
		chk("ready next", 32'(1 << ch), {28'h0, ready});
		pulse(0);
		chk("ready idle", 32'h0, {28'h0, ready});
		cmd(OP_READ_STATUS, 4'h0);
		rd(READ_DATA_OFFSET, 32'hff, 32'h0, "idle data");
		chk("starts", 32'(m_start), 32'(start_total));
		pulse(1);
		rd(STATUS_OFFSET, 32'h2, 32'h0, "flash after play");
		// resonator stops
		apb(1'b1, IRQ_STAT_OFFSET, 32'h7);
		apb(1'b1, IRQ_MASK_OFFSET, 32'h2);
		cmd(OP_PLAY, 4'(ch));
		chk("ready replay", 32'(1 << ch), {28'h0, ready});
		xtal_run <= 1'b0;
		w = 0;
		while (irq !== 1'b1 && w < 400) begin
			@(posedge clk_in);
			w++;
		end
		chk("osc irq", 32'h1, {31'h0, irq});
		cmd(OP_READ_ERROR, 4'h0);
		chk("busy held", 32'h0, {31'h0, busy_n});
		w = 0;
		while (busy_n !== 1'b1 && w < 400) begin
			@(posedge clk_in);
			w++;
		end
		chk("rc mode", 32'h1, {31'h0, rc_mode});
		rd(READ_DATA_OFFSET, 32'h3, 32'h2, "osc data");
		cmd(OP_STOP, 4'(ch));
		chk("ready stopped", 32'h0, {28'h0, ready});
		cmd(OP_POWER_DOWN, 4'h0);
		give_verdict();
	end
endmodule : speech_playback_command_sequencing_test
